// [dv/sad_cpu_model.sv]
module sad_cpu_model (
  input  wire logic          clk,
  output sad_pkg::sad_cyc_s  cyc
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cyc = '0;
  end

  // Presents one cycle for exactly one sampling edge, then drops valid and inverts io, wr and the address lines.
  task automatic run(input logic io, input logic wr, input logic [31:0] addr);
    @(posedge clk);
    #1;
    cyc = '{valid: 1'b1, io: io, wr: wr, addr: addr};
    @(posedge clk);
    #1;
    cyc = '{valid: 1'b0, io: ~io, wr: ~wr, addr: ~addr};
  endtask : run
endmodule : sad_cpu_model

// [dv/sad_decoder_test.sv]
module sad_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic              ref_clk;
  logic              nrst;
  sad_pkg::sad_cyc_s cpu_cyc;
  logic [3:0]        bank_present;
  logic [3:0]        bank_is_4mb;
  logic [3:0]        dram_bank;
  logic [2:0]        tmr_out;
  logic [7:0]        drq_in;
  logic [15:0]       irq_in;
  logic [15:0]       irq_mask;
  sad_pkg::sad_sel_s sel;
  logic [21:0]       dram_ofs;
  logic [15:0]       rom_ofs;
  logic              fpu_busy_clr, fpu_reset, tick, refresh, speaker, dma_casc, casc_in;
  logic [3:0]        dma2_req;
  logic [7:0]        master_irq;
  int                miscompares;
  int                compares;

  sad_cpu_model u_sad_cpu_model (.clk(ref_clk), .cyc(cpu_cyc));

  sad_decoder u_sad_decoder (
    .REF_CLK               (ref_clk),
    .NRST                  (nrst),
    .CPU_CYC               (cpu_cyc),
    .BANK_PRESENT          (bank_present),
    .BANK_IS_4MB           (bank_is_4mb),
    .TMR_OUT               (tmr_out),
    .DRQ_IN                (drq_in),
    .IRQ_IN                (irq_in),
    .IRQ_MASK              (irq_mask),
    .SEL                   (sel),
    .DRAM_BANK             (dram_bank),
    .DRAM_OFS              (dram_ofs),
    .ROM_OFS               (rom_ofs),
    .FPU_BUSY_CLR          (fpu_busy_clr),
    .FPU_RESET             (fpu_reset),
    .TIMER_TICK_REQUEST    (tick),
    .REFRESH_START         (refresh),
    .SPEAKER_OUT           (speaker),
    .DMA_CASCADE_REQUEST   (dma_casc),
    .DMA2_REQ              (dma2_req),
    .CASCADE_REQUEST_INPUT (casc_in),
    .MASTER_IRQ            (master_irq)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic io_decode();
    logic [9:0] ports [15] = '{10'h000, 10'h01F, 10'h020, 10'h03F, 10'h040, 10'h05F, 10'h060, 10'h070,
                               10'h07F, 10'h080, 10'h0A0, 10'h0C0, 10'h0DF, 10'h0E0, 10'h3F8};
    int         pos [15]   = '{13, 13, 12, 12, 11, 11, 10, 9, 9, 8, 7, 6, 6, 0, 0};
    for (int i = 0; i < 15; i++) begin
      u_sad_cpu_model.run(1'b1, 1'b0, {22'h2AAAAA, ports[i]});
      check(32'(sel), 32'h1 << pos[i], "io select");
    end
    u_sad_cpu_model.run(1'b1, 1'b1, 32'h0000_00F0);
    check({sel, fpu_busy_clr, fpu_reset}, 32'h2, "busy clear");
    step();
    check({fpu_busy_clr, fpu_reset}, 32'h0, "busy clear pulse");
    u_sad_cpu_model.run(1'b1, 1'b1, 32'hFFFF_FCF1);
    check({sel, fpu_busy_clr, fpu_reset}, 32'h1, "fpu reset");
    u_sad_cpu_model.run(1'b1, 1'b0, 32'h0000_00F0);
    check({sel, fpu_busy_clr, fpu_reset}, 32'h0, "fpu read");
  endtask : io_decode

  task automatic mem_hit(input logic [31:0] addr, input logic [3:0] bank, input logic [21:0] ofs);
    u_sad_cpu_model.run(1'b0, 1'b0, addr);
    check({dram_bank, dram_ofs}, {bank, ofs}, "dram bank");
  endtask : mem_hit

  task automatic mem_map();
    logic [31:0] regions [5] = '{32'h000A_0000, 32'h000B_FFFF, 32'h000C_0000, 32'h000E_FFFF, 32'h000F_0000};
    logic [13:0] exp [5]     = '{14'h011, 14'h011, 14'h009, 14'h009, 14'h004};
    for (int i = 0; i < 5; i++) begin
      u_sad_cpu_model.run(1'b0, 1'b1, regions[i]);
      check({sel, dram_bank}, {exp[i], 4'h0}, "fixed region");
    end
    mem_hit(32'h0009_FFFF, 4'b0001, 22'h09FFFF);
    check(32'(sel.conv_ram), 32'h1, "conv ram");
    mem_hit(32'h0015_0000, 4'b0010, 22'h050000);
    check(32'(sel.dram), 32'h1, "user ram");
    u_sad_cpu_model.run(1'b0, 1'b0, 32'hAAFF_1234);
    check({sel, rom_ofs}, {14'h004, 16'h1234}, "rom alias");
    u_sad_cpu_model.run(1'b0, 1'b0, 32'h000F_1234);
    check({sel, rom_ofs}, {14'h004, 16'h1234}, "rom low");
    bank_is_4mb = 4'b0001;
    mem_hit(32'h003F_FFFF, 4'b0001, 22'h3FFFFF);
    mem_hit(32'h004F_FFFF, 4'b0010, 22'h0FFFFF);
    mem_hit(32'h0050_0000, 4'b0000, 22'h000000);
    check(32'(sel.expansion), 32'h1, "ram beyond banks");
    bank_present = 4'hF;
    bank_is_4mb  = 4'hF;
    mem_hit(32'h55FE_FFFF, 4'b1000, 22'h3EFFFF);
  endtask : mem_map

  task automatic timers();
    tmr_out = 3'b010;
    step();
    check({refresh, tick, speaker}, 32'h4, "refresh start");
    tmr_out = 3'b111;
    step();
    check({refresh, tick, speaker, master_irq[0]}, 32'h7, "tick and tone");
    tmr_out = 3'b000;
    step();
  endtask : timers

  task automatic irq_dma();
    drq_in = 8'h44;
    irq_in = 16'h0208;
    step();
    check({dma_casc, dma2_req, casc_in, master_irq}, {1'b1, 4'b0101, 1'b1, 8'h0C}, "unmasked");
    irq_mask = 16'h0200;
    step();
    check({casc_in, master_irq}, {1'b0, 8'h08}, "slave masked");
    irq_mask = 16'h0004;
    step();
    check({casc_in, master_irq}, {1'b0, 8'h08}, "cascade masked");
    irq_mask = 16'h0008;
    step();
    check({casc_in, master_irq}, {1'b1, 8'h04}, "master masked");
  endtask : irq_dma

  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    nrst         = 1'b0;
    bank_present = 4'b0011;
    bank_is_4mb  = 4'b0000;
    tmr_out      = 3'b000;
    drq_in       = 8'h00;
    irq_in       = 16'h0000;
    irq_mask     = 16'h0000;
    miscompares  = 0;
    compares     = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    check({sel, fpu_busy_clr, refresh}, 32'h0, "reset state");
    nrst = 1'b1;
    io_decode();
    $display("io_decode finished");
    mem_map();
    $display("mem_map finished");
    timers();
    $display("timers finished");
    irq_dma();
    $display("irq_dma finished");
    complete_run();
  end

  initial begin
    #400000;
    miscompares++;
    complete_run();
  end
endmodule : sad_decoder_test

// [rtl/sad_decoder.sv]
module sad_decoder #(
  parameter int NUM_BANKS = sad_pkg::NUM_BANKS
) (
  input  wire logic                 REF_CLK,
  input  wire logic                 NRST,
  input  wire sad_pkg::sad_cyc_s    CPU_CYC,
  input  wire logic [NUM_BANKS-1:0] BANK_PRESENT,
  input  wire logic [NUM_BANKS-1:0] BANK_IS_4MB,
  input  wire logic [2:0]           TMR_OUT,
  input  wire logic [7:0]           DRQ_IN,
  input  wire logic [15:0]          IRQ_IN,
  input  wire logic [15:0]          IRQ_MASK,
  output sad_pkg::sad_sel_s         SEL,
  output logic [NUM_BANKS-1:0]      DRAM_BANK,
  output logic [21:0]               DRAM_OFS,
  output logic [15:0]               ROM_OFS,
  output logic                      FPU_BUSY_CLR,
  output logic                      FPU_RESET,
  output logic                      TIMER_TICK_REQUEST,
  output logic                      REFRESH_START,
  output logic                      SPEAKER_OUT,
  output logic                      DMA_CASCADE_REQUEST,
  output logic [3:0]                DMA2_REQ,
  output logic                      CASCADE_REQUEST_INPUT,
  output logic [7:0]                MASTER_IRQ
);

  function automatic logic in_io(input logic [9:0] p, input logic [9:0] lo, input logic [9:0] hi);
    in_io = (p >= lo) && (p <= hi);
  endfunction : in_io

  function automatic logic [24:0] bank_size(input logic present, input logic is_4mb);
    if (!present) begin
      bank_size = 25'h0000000;
    end else if (is_4mb) begin
      bank_size = sad_pkg::BANK_SIZE_4MB;
    end else begin
      bank_size = sad_pkg::BANK_SIZE_1MB;
    end
  endfunction : bank_size

  logic [9:0]           port;
  logic [23:0]          maddr;
  sad_pkg::sad_sel_s    sel_d;
  logic [NUM_BANKS-1:0] bank_d;
  logic [21:0]          ofs_d;
  logic                 ram_region;
  logic                 tmr1_prev_q;
  logic [7:0]           slave_irq;

  assign port  = CPU_CYC.addr[9:0];
  assign maddr = CPU_CYC.addr[23:0];
  assign ram_region = (maddr <= sad_pkg::MEM_CONV_HI) ||
                      ((maddr >= sad_pkg::MEM_USER_LO) && (maddr <= sad_pkg::MEM_USER_HI));

  // Banks are stacked from address zero in bank order, so a gap would shift every later bank.
  always_comb begin
    logic [24:0] base;
    logic [24:0] size;
    base   = 25'h0000000;
    size   = 25'h0000000;
    bank_d = '0;
    ofs_d  = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      size = bank_size(BANK_PRESENT[b], BANK_IS_4MB[b]);
      if (ram_region && ({1'b0, maddr} >= base) && ({1'b0, maddr} < base + size)) begin
        bank_d[b] = 1'b1;
        ofs_d     = 22'({1'b0, maddr} - base);
      end
      base = base + size;
    end
  end

  always_comb begin
    sel_d = '0;
    if (CPU_CYC.valid && CPU_CYC.io) begin
      sel_d.dma1     = in_io(port, sad_pkg::IO_DMA1_LO, sad_pkg::IO_DMA1_HI);
      sel_d.pic1     = in_io(port, sad_pkg::IO_PIC1_LO, sad_pkg::IO_PIC1_HI);
      sel_d.timer    = in_io(port, sad_pkg::IO_TMR_LO, sad_pkg::IO_TMR_HI);
      sel_d.kbd      = in_io(port, sad_pkg::IO_KBD_LO, sad_pkg::IO_KBD_HI);
      sel_d.rtc      = in_io(port, sad_pkg::IO_RTC_LO, sad_pkg::IO_RTC_HI);
      sel_d.dma_page = in_io(port, sad_pkg::IO_PAGE_LO, sad_pkg::IO_PAGE_HI);
      sel_d.pic2     = in_io(port, sad_pkg::IO_PIC2_LO, sad_pkg::IO_PIC2_HI);
      sel_d.dma2     = in_io(port, sad_pkg::IO_DMA2_LO, sad_pkg::IO_DMA2_HI);
      sel_d.expansion = !(sel_d.dma1 || sel_d.pic1 || sel_d.timer || sel_d.kbd || sel_d.rtc ||
                          sel_d.dma_page || sel_d.pic2 || sel_d.dma2 ||
                          (port == sad_pkg::IO_FPU_CLR) || (port == sad_pkg::IO_FPU_RST));
    end else if (CPU_CYC.valid) begin
      sel_d.conv_ram = maddr <= sad_pkg::MEM_CONV_HI;
      sel_d.video    = (maddr >= sad_pkg::MEM_VIDEO_LO) && (maddr < sad_pkg::MEM_XROM_LO);
      sel_d.exp_rom  = (maddr >= sad_pkg::MEM_XROM_LO) && (maddr < sad_pkg::MEM_BROM_LO);
      sel_d.boot_rom = ((maddr >= sad_pkg::MEM_BROM_LO) && (maddr <= sad_pkg::MEM_BROM_HI)) ||
                       (maddr >= sad_pkg::MEM_BROM_ALIAS);
      sel_d.dram     = |bank_d;
      // Video and expansion ROM live on cards; so does RAM beyond the populated banks.
      sel_d.expansion = !(sel_d.dram || sel_d.boot_rom);
      if (sel_d.conv_ram && !sel_d.dram) begin
        sel_d.conv_ram = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      SEL       <= '0;
      DRAM_BANK <= '0;
      DRAM_OFS  <= '0;
      ROM_OFS   <= '0;
    end else begin
      SEL       <= sel_d;
      DRAM_BANK <= (CPU_CYC.valid && !CPU_CYC.io) ? bank_d : '0;
      DRAM_OFS  <= ofs_d;
      ROM_OFS   <= maddr[15:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      FPU_BUSY_CLR <= 1'b0;
      FPU_RESET    <= 1'b0;
    end else begin
      FPU_BUSY_CLR <= CPU_CYC.valid && CPU_CYC.io && CPU_CYC.wr && (port == sad_pkg::IO_FPU_CLR);
      FPU_RESET    <= CPU_CYC.valid && CPU_CYC.io && CPU_CYC.wr && (port == sad_pkg::IO_FPU_RST);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      TIMER_TICK_REQUEST <= 1'b0;
      REFRESH_START      <= 1'b0;
      SPEAKER_OUT        <= 1'b0;
      tmr1_prev_q        <= 1'b0;
    end else begin
      TIMER_TICK_REQUEST <= TMR_OUT[0];
      REFRESH_START      <= TMR_OUT[1] && !tmr1_prev_q;
      tmr1_prev_q        <= TMR_OUT[1];
      SPEAKER_OUT        <= TMR_OUT[2];
    end
  end

  // Channel 4 of the second DMA controller carries the first controller's requests.
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      DMA_CASCADE_REQUEST <= 1'b0;
      DMA2_REQ            <= '0;
    end else begin
      DMA_CASCADE_REQUEST <= |DRQ_IN[3:0];
      DMA2_REQ            <= {DRQ_IN[7:5], |DRQ_IN[3:0]};
    end
  end

  assign slave_irq = IRQ_IN[15:8] & ~IRQ_MASK[15:8];

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      CASCADE_REQUEST_INPUT <= 1'b0;
      MASTER_IRQ            <= '0;
    end else begin
      CASCADE_REQUEST_INPUT <= |slave_irq && !IRQ_MASK[2];
      MASTER_IRQ <= {IRQ_IN[7:3], |slave_irq, IRQ_IN[1], TMR_OUT[0]} & ~IRQ_MASK[7:0];
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  chk_io_ten_bits: assert property (CPU_CYC.valid && CPU_CYC.io && (CPU_CYC.addr[15:10] != 6'h00) &&
    (CPU_CYC.addr[9:0] <= sad_pkg::IO_DMA1_HI) |=> SEL.dma1 && !SEL.expansion)
    else $error("high port bits changed the dma select");
  chk_timer_sel: assert property (CPU_CYC.valid && CPU_CYC.io && (CPU_CYC.addr[9:0] == 10'h05F) |=>
    SEL.timer && !SEL.pic1 && !SEL.dma1)
    else $error("timer select wrong at top of its range");
  chk_fpu_clear: assert property (FPU_BUSY_CLR |-> $past(CPU_CYC.wr) && $past(CPU_CYC.io) &&
    ($past(CPU_CYC.addr[9:0]) == sad_pkg::IO_FPU_CLR))
    else $error("busy clear without a write to its port");
  chk_video_map: assert property (CPU_CYC.valid && !CPU_CYC.io && (CPU_CYC.addr[23:0] == 24'h0BFFFF) |=>
    SEL.video && !SEL.exp_rom && !SEL.dram)
    else $error("video region decode wrong");
  chk_user_dram: assert property (SEL.dram |-> $past(CPU_CYC.addr[23:0]) <= sad_pkg::MEM_USER_HI)
    else $error("dram selected above user memory");
  chk_rom_alias: assert property (CPU_CYC.valid && !CPU_CYC.io && (CPU_CYC.addr[23:16] == 8'hFF) |=>
    SEL.boot_rom && (ROM_OFS == $past(CPU_CYC.addr[15:0])) && !SEL.dram)
    else $error("boot rom alias not decoded");
  chk_tick_irq: assert property (MASTER_IRQ[0] |-> $past(TMR_OUT[0]) && !$past(IRQ_MASK[0]))
    else $error("tick interrupt without timer output");
  chk_refresh_pulse: assert property ($rose(TMR_OUT[1]) |=> REFRESH_START ##1 !REFRESH_START)
    else $error("refresh start not a single pulse");
  chk_speaker_follow: assert property ($changed(TMR_OUT[2]) |=> SPEAKER_OUT == $past(TMR_OUT[2]))
    else $error("speaker does not follow timer output");
  chk_dma_cascade: assert property ($past(NRST) |-> (DMA_CASCADE_REQUEST == $past(|DRQ_IN[3:0])) &&
    (DMA2_REQ[0] == DMA_CASCADE_REQUEST))
    else $error("cascade request not on channel four");
  chk_irq_cascade: assert property ($past(NRST) |->
    (CASCADE_REQUEST_INPUT == $past((|(IRQ_IN[15:8] & ~IRQ_MASK[15:8])) && !IRQ_MASK[2])) &&
    (MASTER_IRQ[2] == CASCADE_REQUEST_INPUT))
    else $error("slave request not on master input two");
  chk_bank_onehot: assert property ($onehot0(DRAM_BANK) && (SEL.dram == (|DRAM_BANK)))
    else $error("bank select not one-hot");
  chk_bank_size: assert property (CPU_CYC.valid && !CPU_CYC.io && BANK_PRESENT[1:0] == 2'b11 &&
    BANK_IS_4MB[0] && (CPU_CYC.addr[23:0] == 24'h3FFFFF) |=> DRAM_BANK[0])
    else $error("4MB bank size not decoded");
  chk_rtc_sel: assert property (CPU_CYC.valid && CPU_CYC.io && (CPU_CYC.addr[9:0] == 10'h070) |=> SEL.rtc)
    else $error("clock ports not selected");
  chk_upper_ignored: assert property (CPU_CYC.valid && !CPU_CYC.io &&
    (CPU_CYC.addr[23:0] == sad_pkg::MEM_BROM_LO) |=> SEL.boot_rom)
    else $error("upper address bits changed decode");
  chk_expansion_only: assert property (SEL.expansion |-> !SEL.dram && !SEL.boot_rom && !SEL.timer &&
    !SEL.dma1 && !SEL.rtc && (DRAM_BANK == '0))
    else $error("expansion forward with on-board select");

endmodule : sad_decoder

// [shared/sad_pkg.sv]
package sad_pkg;
  localparam int ADDR_W = 24;
  localparam int IO_W   = 10;

  localparam logic [9:0] IO_DMA1_LO  = 10'h000;
  localparam logic [9:0] IO_DMA1_HI  = 10'h01F;
  localparam logic [9:0] IO_PIC1_LO  = 10'h020;
  localparam logic [9:0] IO_PIC1_HI  = 10'h03F;
  localparam logic [9:0] IO_TMR_LO   = 10'h040;
  localparam logic [9:0] IO_TMR_HI   = 10'h05F;
  localparam logic [9:0] IO_KBD_LO   = 10'h060;
  localparam logic [9:0] IO_KBD_HI   = 10'h06F;
  localparam logic [9:0] IO_RTC_LO   = 10'h070;
  localparam logic [9:0] IO_RTC_HI   = 10'h07F;
  localparam logic [9:0] IO_PAGE_LO  = 10'h080;
  localparam logic [9:0] IO_PAGE_HI  = 10'h09F;
  localparam logic [9:0] IO_PIC2_LO  = 10'h0A0;
  localparam logic [9:0] IO_PIC2_HI  = 10'h0BF;
  localparam logic [9:0] IO_DMA2_LO  = 10'h0C0;
  localparam logic [9:0] IO_DMA2_HI  = 10'h0DF;
  localparam logic [9:0] IO_FPU_CLR  = 10'h0F0;
  localparam logic [9:0] IO_FPU_RST  = 10'h0F1;

  localparam logic [23:0] MEM_CONV_HI    = 24'h09FFFF;
  localparam logic [23:0] MEM_VIDEO_LO   = 24'h0A0000;
  localparam logic [23:0] MEM_XROM_LO    = 24'h0C0000;
  localparam logic [23:0] MEM_BROM_LO    = 24'h0F0000;
  localparam logic [23:0] MEM_BROM_HI    = 24'h0FFFFF;
  localparam logic [23:0] MEM_USER_LO    = 24'h100000;
  localparam logic [23:0] MEM_USER_HI    = 24'hFEFFFF;
  localparam logic [23:0] MEM_BROM_ALIAS = 24'hFF0000;

  localparam logic [24:0] BANK_SIZE_1MB = 25'h0100000;
  localparam logic [24:0] BANK_SIZE_4MB = 25'h0400000;
  localparam int          NUM_BANKS     = 4;

  typedef struct packed {
    logic        valid;
    logic        io;
    logic        wr;
    logic [31:0] addr;
  } sad_cyc_s;

  typedef struct packed {
    logic dma1;
    logic pic1;
    logic timer;
    logic kbd;
    logic rtc;
    logic dma_page;
    logic pic2;
    logic dma2;
    logic conv_ram;
    logic video;
    logic exp_rom;
    logic boot_rom;
    logic dram;
    logic expansion;
  } sad_sel_s;
endpackage : sad_pkg
